// ### logic/imc_ctrl.sv
// imc_ctrl: maskable interrupt controller top with register port and entry sequencer
// assumes an AXI4-Lite master on ref_clk, a cpu core giving instruction boundaries,
// and a vector memory that returns read data one cycle after mem_rd
//
// Chosen here: register access over AXI4-Lite.
module imc_ctrl
   import imc_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // axi4-lite write
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic      [1:0]        s_axi_bresp,
   // axi4-lite read
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   // peripheral requests and pins (one, three, zero)
   input  wire logic [NSRC-1:0]   src_req,
   input  wire logic [NEXT-1:0]   ext_pin_n,
   // cpu side
   input  wire logic              instr_done,
   input  wire logic              instr_susp,
   input  wire logic              sw_req,
   input  wire logic [5:0]        sw_num,
   input  wire logic [ADDR_W-1:0] cpu_pc,
   input  wire logic [ADDR_W-1:0] vec_rdata,
   output logic                   entry_busy,
   output logic      [5:0]        entry_num,
   output logic                   mem_rd,
   output logic      [ADDR_W-1:0] mem_addr,
   output logic                   push_valid,
   output logic      [ADDR_W-1:0] push_data,
   output logic                   pc_load,
   output logic      [ADDR_W-1:0] pc_value,
   output logic      [FLG_W-1:0]  flag_out
);
   imc_state_t          state_r;
   logic [4:0]          step_r;
   logic [5:0]          num_r;
   logic [2:0]          lvl_r;
   logic                sw_r;
   logic [FLG_W-1:0]    flags_r;
   logic [FLG_W-1:0]    temp_r;
   logic [ADDR_W-1:0]   pc_save_r;
   logic [ADDR_W-1:0]   vec_r;
   logic [ADDR_W-1:0]   vbase_r;
   logic [NEXT-1:0]     extcfg_r;
   logic                mem_rd_r;
   logic [ADDR_W-1:0]   mem_addr_r;
   logic                push_valid_r;
   logic [ADDR_W-1:0]   push_data_r;
   logic                pc_load_r;
   logic [2:0]          cpu_priority_threshold;
   logic                start;
   logic                start_m;
   logic                start_sw;
   logic [ADDR_W-1:0]   vec_addr;
   // axi state
   logic                aw_hold_r;
   logic                w_hold_r;
   logic [9:0]          aw_ix_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic                bvalid_r;
   logic [1:0]          bresp_r;
   logic                rvalid_r;
   logic [31:0]         rdata_r;
   logic [1:0]          rresp_r;
   logic                wr_do;
   // sources
   logic [NSRC-1:0]     set_src;
   logic [NSRC-1:0]     pend_v;
   logic [NSRC-1:0]     edge_v;
   logic [NSRC-1:0]     ack_v;
   logic [NSRC-1:0]     wr_v;
   logic [7:0]          ctl_v [NSRC];
   logic [NEXT-1:0]     pin_s1_r;
   logic [NEXT-1:0]     pin_s2_r;
   logic [NEXT-1:0]     pin_s3_r;
   logic [NEXT-1:0]     ext_evt;

   imc_arb_if arb_if ();

   imc_arb u_arb (
      .a (arb_if.arb)
   );

   // byte lane merge for the wide registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   // ---- axi4-lite write channel: address and data taken in either order
   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready  = !w_hold_r && !bvalid_r;
   assign wr_do         = aw_hold_r && w_hold_r && !bvalid_r;

   // latch address and data until both are present
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         aw_ix_r   <= 10'h000;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_ix_r   <= s_axi_awaddr[AXI_AW-1:2];
         end else if (wr_do) aw_hold_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end else if (wr_do) w_hold_r <= 1'b0;
      end
   end

   // write response, unmapped index answers slverr
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (|wr_v || aw_ix_r == {2'h0, IX_VBASE} || aw_ix_r == {2'h0, IX_FLAGS} ||
                      aw_ix_r == {2'h0, IX_EXTCFG}) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_r <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // ---- axi4-lite read channel: one cycle to data
   assign s_axi_arready = !rvalid_r;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_SLVERR;
         for (int i = 0; i < NSRC; i++) begin
            if (s_axi_araddr[AXI_AW-1:2] == {2'h0, SRC_IX[i]}) begin
               rdata_r <= {24'h0, ctl_v[i]};
               rresp_r <= RESP_OKAY;
            end
         end
         if (s_axi_araddr[AXI_AW-1:2] == {2'h0, IX_VBASE}) begin
            rdata_r <= {12'h0, vbase_r};
            rresp_r <= RESP_OKAY;
         end
         if (s_axi_araddr[AXI_AW-1:2] == {2'h0, IX_FLAGS}) begin
            rdata_r <= {17'h0, flags_r};
            rresp_r <= RESP_OKAY;
         end
         if (s_axi_araddr[AXI_AW-1:2] == {2'h0, IX_EXTCFG}) begin
            rdata_r <= {29'h0, extcfg_r};
            rresp_r <= RESP_OKAY;
         end
      end else if (s_axi_rready) rvalid_r <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

   // ---- vector base and both-edge configuration
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         vbase_r  <= VBASE_RST;
         extcfg_r <= 3'h0;
      end else if (wr_do) begin
         if (aw_ix_r == {2'h0, IX_VBASE}) vbase_r <= ADDR_W'(merge({12'h0, vbase_r}, wdata_r, wstrb_r));
         if (aw_ix_r == {2'h0, IX_EXTCFG} && wstrb_r[0]) extcfg_r <= wdata_r[NEXT-1:0];
      end
   end

   // ---- pin synchronisers and edge detection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_s1_r <= 3'h7;
         pin_s2_r <= 3'h7;
         pin_s3_r <= 3'h7;
      end else begin
         pin_s1_r <= ext_pin_n;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // falling or rising per edge select, both when configured
   always_comb begin
      for (int k = 0; k < NEXT; k++) begin
         ext_evt[k] = extcfg_r[k] ? (pin_s2_r[k] != pin_s3_r[k]) :
                      edge_v[EXT_ONE + k] ? (pin_s2_r[k] && !pin_s3_r[k]) :
                      (!pin_s2_r[k] && pin_s3_r[k]);
      end
   end

   // ---- source cells, index order is ascending interrupt number
   generate
      for (genvar g = 0; g < NSRC; g++) begin : g_src
         localparam bit EXT = (g >= EXT_ONE) && (g <= EXT_ZERO);
         localparam int PIN = EXT ? g - EXT_ONE : 0; // keeps the pin index in range
         assign set_src[g] = EXT ? ext_evt[PIN] : src_req[g];
         assign wr_v[g]    = wr_do && wstrb_r[0] && (aw_ix_r == {2'h0, SRC_IX[g]});
         assign ack_v[g]   = start_m && (arb_if.win == 5'(g));
         assign arb_if.pend[g] = pend_v[g];

         imc_src_cell #(
            .IS_EXT   (EXT),
            .IS_MULTI (g <= MULTI_RC)
         ) u_cell (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .wr_en    (wr_v[g]),
            .wr_data  (wdata_r[7:0]),
            .ctl      (ctl_v[g]),
            .set_req  (set_src[g]),
            .ack_clr  (ack_v[g]),
            .lvl      (arb_if.lvl[g]),
            .pend     (pend_v[g]),
            .edge_sel (edge_v[g])
         );
      end
   endgenerate

   // ---- acceptance
   assign cpu_priority_threshold           = flags_r[FLG_IPL_LO +: 3];
   assign arb_if.thresh = cpu_priority_threshold;
   assign start_sw = (state_r == ST_IDLE) && instr_done && sw_req;
   assign start_m  = (state_r == ST_IDLE) && !start_sw && (instr_done || instr_susp) &&
                     flags_r[FLG_I] && arb_if.win_ok;
   assign start    = start_sw || start_m;
   assign vec_addr = vbase_r + {12'h000, num_r, 2'b00};

   // state and step counter of the entry sequence
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         step_r  <= 5'h00;
      end else begin
         case (state_r)
            ST_IDLE: begin
               step_r <= 5'h00;
               if (start) state_r <= ST_ENTRY;
            end
            ST_ENTRY: begin
               step_r <= step_r + 5'h01;
               if (step_r == STP_LAST) state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // capture of the accepted source and the context
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         num_r     <= 6'h00;
         lvl_r     <= 3'h0;
         sw_r      <= 1'b0;
         temp_r    <= FLAGS_RST;
         pc_save_r <= 20'h00000;
         vec_r     <= 20'h00000;
      end else if (start) begin
         num_r     <= start_sw ? sw_num : SRC_NUM[arb_if.win];
         lvl_r     <= arb_if.win_lvl;
         sw_r      <= start_sw;
         temp_r    <= flags_r;
         pc_save_r <= cpu_pc;
      end else if (state_r == ST_ENTRY && step_r == STP_VCAP) begin
         vec_r <= vec_rdata;
      end
   end

   // flag register: software writes, entry overrides
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) flags_r <= FLAGS_RST;
      else if (state_r == ST_ENTRY && step_r == 5'h00) begin
         flags_r[FLG_I] <= 1'b0;
         flags_r[FLG_D] <= 1'b0;
         if (!(sw_r && num_r >= SW_KEEPU_LO)) flags_r[FLG_U] <= 1'b0;
      end else if (state_r == ST_ENTRY && step_r == STP_IPL && !sw_r) begin
         flags_r[FLG_IPL_LO +: 3] <= lvl_r;
      end else if (wr_do && aw_ix_r == {2'h0, IX_FLAGS}) begin
         flags_r <= FLG_W'(merge({17'h0, flags_r}, wdata_r, wstrb_r));
      end
   end

   // sequencer outputs, pushes visible in the step they name, vector read and pc load one step after STP_VEC and STP_LOAD
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mem_rd_r     <= 1'b0;
         mem_addr_r   <= ACK_ADDR;
         push_valid_r <= 1'b0;
         push_data_r  <= 20'h00000;
         pc_load_r    <= 1'b0;
      end else begin
         mem_rd_r     <= 1'b0;
         push_valid_r <= 1'b0;
         pc_load_r    <= 1'b0;
         if (start) begin
            mem_rd_r   <= 1'b1;
            mem_addr_r <= ACK_ADDR;
         end else if (state_r == ST_ENTRY) begin
            case (step_r)
               STP_PUSHF - 5'h01: begin
                  push_valid_r <= 1'b1;
                  push_data_r  <= {5'h00, temp_r};
               end
               STP_PUSHPC - 5'h01: begin
                  push_valid_r <= 1'b1;
                  push_data_r  <= pc_save_r;
               end
               STP_VEC: begin
                  mem_rd_r   <= 1'b1;
                  mem_addr_r <= vec_addr;
               end
               STP_LOAD: pc_load_r <= 1'b1;
               default: ;
            endcase
         end
      end
   end

   assign entry_busy = (state_r == ST_ENTRY);
   assign entry_num  = num_r;
   assign mem_rd     = mem_rd_r;
   assign mem_addr   = mem_addr_r;
   assign push_valid = push_valid_r;
   assign push_data  = push_data_r;
   assign pc_load    = pc_load_r;
   assign pc_value   = vec_r;
   assign flag_out   = flags_r;

   // ---- checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_push;
      (push_valid_r && push_data_r == {5'h00, temp_r}) ##1 (push_valid_r && push_data_r == pc_save_r);
   endsequence

   a_entry_len: assert property (start |-> ##20 pc_load_r) else $error("entry length wrong");
   a_info_read: assert property (start |=> mem_rd_r && mem_addr_r == ACK_ADDR) else $error("no info read");
   a_accept_cond: assert property (start_m |-> flags_r[FLG_I] && arb_if.win_lvl > cpu_priority_threshold) else $error("bad accept");
   a_thresh_block: assert property (cpu_priority_threshold == 3'h7 |-> !start_m) else $error("threshold 7 leaked");
   a_sw_free: assert property (state_r == ST_IDLE && instr_done && sw_req |=> entry_busy) else $error("sw lost");
   a_flags_clr: assert property (start |-> ##2 !flags_r[FLG_I] && !flags_r[FLG_D]) else $error("flags kept");
   a_push_order: assert property (start |-> ##2 s_push) else $error("push order wrong");
   a_ipl_load: assert property (start_m |-> ##5 cpu_priority_threshold == $past(arb_if.win_lvl, 5)) else $error("ipl not loaded");
   a_vec_fetch: assert property (start |-> ##6 mem_rd_r && mem_addr_r == vec_addr) else $error("bad vector");
endmodule

// ### pkg/imc_pkg.sv
// imc_pkg: constants, register map and types of the maskable interrupt controller
// assumes a single 125 MHz clock domain and an AXI4-Lite register port with 32-bit data
package imc_pkg;
   // source table, ordered by ascending interrupt number
   localparam int NSRC = 17;
   localparam logic [7:0] SRC_IX [NSRC] = '{8'h41, 8'h47, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h51, 8'h52,
                                            8'h56, 8'h58, 8'h59, 8'h5a, 8'h5d, 8'h5e, 8'h72, 8'h73};
   localparam logic [5:0] SRC_NUM [NSRC] = '{6'h01, 6'h07, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h11, 6'h12,
                                             6'h16, 6'h18, 6'h19, 6'h1a, 6'h1d, 6'h1e, 6'h32, 6'h33};
   localparam int MULTI_FLASH = 0;
   localparam int MULTI_RC    = 1;
   localparam int EXT_ONE     = 11;
   localparam int EXT_THREE   = 12;
   localparam int EXT_ZERO    = 13;
   localparam int NEXT        = 3;
   // extra register indices (byte address is four times the index)
   localparam logic [7:0] IX_VBASE  = 8'h80;
   localparam logic [7:0] IX_FLAGS  = 8'h81;
   localparam logic [7:0] IX_EXTCFG = 8'h82;
   localparam int AXI_AW = 12;
   // control register fields
   localparam int CTL_LVL_LO = 0;
   localparam int CTL_PEND   = 3;
   localparam int CTL_EDGE   = 4;
   // flag register fields
   localparam int FLG_W      = 15;
   localparam int FLG_D      = 2;
   localparam int FLG_I      = 6;
   localparam int FLG_U      = 7;
   localparam int FLG_IPL_LO = 12;
   localparam logic [FLG_W-1:0] FLAGS_RST = 15'h0000;
   // memory side
   localparam int ADDR_W = 20;
   localparam logic [ADDR_W-1:0] ACK_ADDR  = 20'h00000;
   localparam logic [ADDR_W-1:0] VBASE_RST = 20'h00000;
   localparam int VEC_TBL_BYTES = 256;
   // software numbers that keep the stack select flag
   localparam logic [5:0] SW_KEEPU_LO = 6'h20;
   // entry sequence step numbers and length in cycles
   localparam int ENTRY_CYC = 20;
   localparam logic [4:0] STP_PUSHF = 5'h01;
   localparam logic [4:0] STP_PUSHPC = 5'h02;
   localparam logic [4:0] STP_IPL   = 5'h03;
   localparam logic [4:0] STP_VEC   = 5'h04;
   localparam logic [4:0] STP_VCAP  = 5'h06;
   localparam logic [4:0] STP_LOAD  = 5'(ENTRY_CYC - 2);
   localparam logic [4:0] STP_LAST  = 5'(ENTRY_CYC - 1);
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ENTRY = 2'b10} imc_state_t;
endpackage

// ### pkg/imc_arb_if.sv
// imc_arb_if: pending flags and levels toward the arbiter, winner back
// assumes both ends sit in the same clock domain
interface imc_arb_if;
   import imc_pkg::*;
   logic [NSRC-1:0] pend;
   logic [2:0]      lvl [NSRC];
   logic [2:0]      thresh;
   logic [4:0]      win;
   logic [2:0]      win_lvl;
   logic            win_ok;
   modport arb (input pend, lvl, thresh, output win, win_lvl, win_ok);
   modport ctl (output pend, lvl, thresh, input win, win_lvl, win_ok);
endinterface

// ### logic/imc_arb.sv
// imc_arb: picks the highest pending level above the threshold
// assumes combinational use inside one clock domain
module imc_arb
   import imc_pkg::*;
(
   // request side
   imc_arb_if.arb a
);
   // scan downward so that on equal level the lower number wins
   always_comb begin
      a.win     = 5'h00;
      a.win_lvl = 3'h0;
      a.win_ok  = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (a.pend[i] && (a.lvl[i] > a.thresh) && (a.lvl[i] >= a.win_lvl)) begin
            a.win     = 5'(i);
            a.win_lvl = a.lvl[i];
            a.win_ok  = 1'b1;
         end
      end
   end
endmodule

// ### logic/imc_src_cell.sv
// imc_src_cell: one source control register with level, pending and edge select
// assumes write strobes and requests come from the same clock domain
module imc_src_cell
   import imc_pkg::*;
#(
   parameter bit IS_EXT   = 1'b0,
   parameter bit IS_MULTI = 1'b0
)(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // register access
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] ctl,
   // request and acceptance
   input  wire logic       set_req,
   input  wire logic       ack_clr,
   output logic      [2:0] lvl,
   output logic            pend,
   output logic            edge_sel
);
   logic [2:0] lvl_r;
   logic       pend_r;
   logic       edge_r;
   logic       edge_chg;

   // priority level, 0 disables the source
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) lvl_r <= 3'h0;
      else if (wr_en) lvl_r <= wr_data[CTL_LVL_LO +: 3];
   end

   // edge select, pin sources only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) edge_r <= 1'b0;
      else if (IS_EXT && wr_en) edge_r <= wr_data[CTL_EDGE];
   end

   assign edge_chg = IS_EXT && wr_en && (wr_data[CTL_EDGE] != edge_r);

   // pending: set beats clear, a written 1 does nothing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) pend_r <= 1'b0;
      else if (IS_MULTI) pend_r <= set_req;
      else pend_r <= set_req || edge_chg ||
                     (pend_r && !(wr_en && !wr_data[CTL_PEND]) && !ack_clr);
   end

   assign lvl      = lvl_r;
   assign pend     = pend_r;
   assign edge_sel = edge_r;
   assign ctl      = {3'h0, edge_r, pend_r, lvl_r};
endmodule

// ### sim/imc_cpu_model.sv
// imc_cpu_model: cpu core and vector memory on the far side of the controller
// assumes vector reads are answered one cycle after mem_rd
module imc_cpu_model
   import imc_pkg::*;
(
   // clock and control
   input  wire logic              ref_clk,
   input  wire logic              run,
   // memory side
   input  wire logic              mem_rd,
   input  wire logic [ADDR_W-1:0] mem_addr,
   output logic      [ADDR_W-1:0] vec_rdata = '0,
   // instruction boundaries
   output logic                   instr_done = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_r = 2'h0;
   // an instruction ends every fourth cycle while running
   always @(posedge ref_clk) begin
      cnt_r <= cnt_r + 2'h1;
      instr_done <= run && (cnt_r == 2'h3);
   end
   // memory answers a read, otherwise the bus keeps changing
   always @(posedge ref_clk) begin
      vec_rdata <= mem_rd ? mem_addr + 20'h10000 : ~vec_rdata;
   end
endmodule

// ### sim/tb.sv
// tb: register, entry, priority and software trap tests of the controller
// assumes the cpu model answers vector reads and marks instruction ends
module tb
   import imc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst = 1, run = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [NSRC-1:0] src_req = '0;
   logic [NEXT-1:0] ext_pin_n = '1;
   logic instr_done, instr_susp = 0, sw_req = 0, entry_busy, mem_rd, push_valid, pc_load;
   logic [5:0] sw_num = '0, entry_num;
   logic [ADDR_W-1:0] cpu_pc = 20'h12344, vec_rdata, mem_addr, push_data, pc_value;
   logic [FLG_W-1:0] flag_out;
   int fails = 0, checks = 0, n;
   imc_ctrl uut (.*);
   imc_cpu_model cpu (.*);
   // 125 MHz clock
   always #4 ref_clk = ~ref_clk;
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bit ad, wd;
      ad = 0;
      wd = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ad && wd)) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
         if (s_axi_wvalid && s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      chk("rdata", e, {s_axi_rdata[31:8], 3'h0, s_axi_rdata[4:0]});
      chk("rresp", 32'(r), 32'(s_axi_rresp));
   endtask
   task enter(input logic [5:0] num, input logic [19:0] pc, input bit s);
      logic [19:0] pp, ma;
      pp = '0;
      ma = '0;
      n = 0;
      run <= !s;
      instr_susp <= s;
      repeat (400) begin
         @(posedge ref_clk);
         if (entry_busy) begin n++; sw_req <= 0; end
         if (push_valid) pp = push_data;
         if (mem_rd) ma = mem_addr;
         if (pc_load) break;
      end
      run <= 0;
      instr_susp <= 0;
      chk("cycles", 32'd20, 32'(n));
      chk("number", 32'(num), 32'(entry_num));
      chk("pc", 32'(pc), 32'(pc_value));
      chk("push", 32'(cpu_pc), 32'(pp));
      chk("vaddr", 32'(pc - 20'h10000), 32'(ma));
   endtask
   task t_regs;
      wr(12'h128, 32'h0f);
      rd(12'h128, 32'h7, RESP_OKAY);
      rd(12'h000, 32'h0, RESP_SLVERR);
      wr(12'h104, 32'h0a);
      src_req[0] <= 1;
      wr(12'h104, 32'h02);
      rd(12'h104, 32'ha, RESP_OKAY);
      src_req[0] <= 0;
      wr(12'h174, 32'h01);
      ext_pin_n[2] <= 0;
      repeat (6) @(posedge ref_clk);
      rd(12'h174, 32'h9, RESP_OKAY);
      wr(12'h174, 32'h01);
      rd(12'h174, 32'h1, RESP_OKAY);
      wr(12'h168, 32'h11);
      rd(12'h168, 32'h19, RESP_OKAY);
      wr(12'h168, 32'h11);
      rd(12'h168, 32'h11, RESP_OKAY);
      wr(12'h208, 32'h4);
      ext_pin_n[2] <= 1;
      repeat (6) @(posedge ref_clk);
      rd(12'h174, 32'h9, RESP_OKAY);
      wr(12'h174, 32'h01);
      $display("t_regs done");
   endtask
   task t_entry;
      wr(12'h200, 32'h01000);
      wr(12'h204, 32'h40);
      @(posedge ref_clk);
      src_req <= 17'h4;
      @(posedge ref_clk);
      src_req <= '0;
      rd(12'h128, 32'hf, RESP_OKAY);
      enter(6'd10, 20'h11028, 1'b0);
      chk("ipl", 32'h7, 32'(flag_out[14:12]));
      chk("iflag", 32'h0, 32'(flag_out[6]));
      rd(12'h128, 32'h7, RESP_OKAY);
      $display("t_entry done");
   endtask
   task t_prio;
      wr(12'h12c, 32'h3);
      wr(12'h130, 32'h5);
      wr(12'h134, 32'h5);
      wr(12'h204, 32'h3040);
      @(posedge ref_clk);
      src_req <= 17'h38;
      @(posedge ref_clk);
      src_req <= '0;
      enter(6'd12, 20'h11030, 1'b0);
      wr(12'h204, 32'h3040);
      enter(6'd13, 20'h11034, 1'b1);
      rd(12'h12c, 32'hb, RESP_OKAY);
      $display("t_prio done");
   endtask
   task t_sw;
      wr(12'h204, 32'h80);
      @(posedge ref_clk);
      sw_num <= 6'd33;
      sw_req <= 1;
      enter(6'd33, 20'h11084, 1'b0);
      chk("uflag", 32'h1, 32'(flag_out[7]));
      $display("t_sw done");
   endtask
   task close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // reset, then the tests in order
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 0;
      t_regs;
      t_entry;
      t_prio;
      t_sw;
      close_out;
   end
   // watchdog against a hung handshake
   initial begin
      #100us;
      fails++;
      close_out;
   end
endmodule
